// ==== ipc_pkg.sv ====
`default_nettype none
package ipc_pkg;

    // Register indexes; byte address on the bus is four times the index
    localparam logic [5:0] IPC_IDX_RSVD_A    = 6'h29;
    localparam logic [5:0] IPC_IDX_LVL_ZC    = 6'h2A;
    localparam logic [5:0] IPC_IDX_RSVD_B    = 6'h2B;
    localparam logic [5:0] IPC_IDX_ROUTING   = 6'h2C;
    localparam logic [5:0] IPC_IDX_AMP_GAIN  = 6'h2D;
    localparam logic [5:0] IPC_IDX_RSVD_C    = 6'h2E;
    localparam logic [5:0] IPC_IDX_BOOST     = 6'h2F;
    localparam logic [5:0] IPC_IDX_STATUS    = 6'h3F;
    localparam int         IPC_ADDR_W        = 8;

    // Field positions
    localparam int IPC_BIT_LVL_ZC      = 1;
    localparam int IPC_BIT_BIAS_SEL    = 8;
    localparam int IPC_BIT_AUX_MODE    = 3;
    localparam int IPC_BIT_AUX_NEG     = 2;
    localparam int IPC_BIT_MIC_NEG     = 1;
    localparam int IPC_BIT_MIC_POS     = 0;
    localparam int IPC_BIT_GAIN_ZC     = 7;
    localparam int IPC_BIT_MUTE        = 6;
    localparam int IPC_GAIN_MSB        = 5;
    localparam int IPC_BIT_BOOST       = 8;
    localparam int IPC_BIT_PENDING     = 8;

    // Values after reset
    localparam logic       IPC_RST_LVL_ZC   = 1'h0;
    localparam logic       IPC_RST_BIAS_SEL = 1'h0;
    localparam logic       IPC_RST_AUX_MODE = 1'h0;
    localparam logic       IPC_RST_AUX_NEG  = 1'h0;
    localparam logic       IPC_RST_MIC_NEG  = 1'h1;
    localparam logic       IPC_RST_MIC_POS  = 1'h0;
    localparam logic       IPC_RST_GAIN_ZC  = 1'h0;
    localparam logic       IPC_RST_MUTE     = 1'h1;
    localparam logic [5:0] IPC_RST_GAIN     = 6'h10;
    localparam logic       IPC_RST_BOOST    = 1'h0;

    // AXI responses
    localparam logic [1:0] IPC_RESP_OKAY    = 2'h0;
    localparam logic [1:0] IPC_RESP_DECERR  = 2'h3;

    // Gain update unit states, Gray along direct -> waiting
    typedef enum logic [1:0] {
        IPC_GU_DIRECT = 2'h0,
        IPC_GU_WAIT   = 2'h1
    } ipc_gu_state_t;

endpackage
`default_nettype wire

// ==== ipc_gain_if.sv ====
`default_nettype none
interface ipc_gain_if;
    logic [5:0] target;
    logic       zc_en;
    logic       wr_pulse;
    logic [5:0] applied;
    logic       pending;

    modport ctrl (output target, output zc_en, output wr_pulse, input applied, input pending);
    modport unit (input target, input zc_en, input wr_pulse, output applied, output pending);
endinterface
`default_nettype wire

// ==== ipc_gain_apply.sv ====
`default_nettype none
module ipc_gain_apply
    import ipc_pkg::*;
(
    input  wire logic  sys_clk,
    input  wire logic  rst,
    input  wire logic  ce,
    input  wire logic  zero_cross,
    ipc_gain_if.unit   gif
);

    ipc_gu_state_t state;
    ipc_gu_state_t next_state;
    logic [5:0]    applied;
    logic [5:0]    next_applied;

    // Decide when the stored gain code reaches the amplifier
    always_comb begin
        next_state   = state;
        next_applied = applied;
        case (state)
            IPC_GU_DIRECT: begin
                if (!gif.zc_en) begin
                    next_applied = gif.target;
                end else if (gif.wr_pulse) begin
                    next_state = IPC_GU_WAIT;
                end
            end
            IPC_GU_WAIT: begin
                // A write in the crossing cycle re-arms, so the newer code waits too
                if (!gif.zc_en) begin
                    next_applied = gif.target;
                    next_state   = IPC_GU_DIRECT;
                end else if (zero_cross && !gif.wr_pulse) begin
                    next_applied = gif.target;
                    next_state   = IPC_GU_DIRECT;
                end
            end
            default: begin
                next_state = IPC_GU_DIRECT;
            end
        endcase
    end

    // State and applied code
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            state   <= IPC_GU_DIRECT;
            applied <= IPC_RST_GAIN;
        end else if (ce) begin
            state   <= next_state;
            applied <= next_applied;
        end
    end

    assign gif.applied = applied;
    assign gif.pending = (state == IPC_GU_WAIT);

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    wait_hold_a: assert property (ce && gif.pending && gif.zc_en && !zero_cross |=> $stable(applied))
        else $error("applied gain moved before a zero crossing");
    cross_apply_a: assert property (ce && gif.pending && gif.zc_en && zero_cross && !gif.wr_pulse
            |=> applied == $past(gif.target) && !gif.pending)
        else $error("zero crossing did not apply the pending gain");
    direct_apply_a: assert property (ce && !gif.zc_en |=> applied == $past(gif.target))
        else $error("gain not applied directly with zero cross off");
    zc_apply_c: cover property (gif.pending ##[1:20] (ce && zero_cross && !gif.pending));

endmodule // ipc_gain_apply
`default_nettype wire

// ==== ipc_input_path_regs.sv ====
// Summary of operation
// - Bit 1 of register 0x2A enables zero-cross waiting for level-control gain steps, reset 0.
// - Bit 8 of register 0x2C selects mic bias, 0 for 0.9 of supply and 1 for 0.75, reset 0.
// - Bit 3 of register 0x2C picks aux mode, 0 inverting buffer, 1 mixer, reset 0.
// - Bit 2 of register 0x2C connects the aux amplifier to the amplifier minus input, reset 0.
// - Bit 1 of register 0x2C connects the negative mic pin to the minus input, reset 1.
// - Bit 0 of register 0x2C ties the plus input to mid rail (0) or positive mic pin (1).
// - Bit 7 of register 0x2D applies a new gain at once (0) or at the next zero crossing (1).
// - Bit 6 of register 0x2D mutes and isolates the input amplifier, reset 1.
// - Bit 8 of register 0x2F adds 20 dB in the boost stage, reset 0.
//
// Decided for this implementation: the AXI4-Lite slave port.
`default_nettype none
module ipc_input_path_regs
    import ipc_pkg::*;
(
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          ce,
    input  wire logic                          zero_cross,
    input  wire logic [ipc_pkg::IPC_ADDR_W-1:0] s_axi_awaddr,
    input  wire logic                          s_axi_awvalid,
    output var  logic                          s_axi_awready,
    input  wire logic [31:0]                   s_axi_wdata,
    input  wire logic [3:0]                    s_axi_wstrb,
    input  wire logic                          s_axi_wvalid,
    output var  logic                          s_axi_wready,
    output var  logic [1:0]                    s_axi_bresp,
    output var  logic                          s_axi_bvalid,
    input  wire logic                          s_axi_bready,
    input  wire logic [ipc_pkg::IPC_ADDR_W-1:0] s_axi_araddr,
    input  wire logic                          s_axi_arvalid,
    output var  logic                          s_axi_arready,
    output var  logic [31:0]                   s_axi_rdata,
    output var  logic [1:0]                    s_axi_rresp,
    output var  logic                          s_axi_rvalid,
    input  wire logic                          s_axi_rready,
    output var  logic                          level_ctl_zero_cross_en,
    output var  logic                          mic_bias_level_sel,
    output var  logic                          aux_input_mode,
    output var  logic                          aux_to_amp_neg_en,
    output var  logic                          mic_neg_to_amp_neg_en,
    output var  logic                          mic_pos_to_amp_pos_sel,
    output var  logic                          amp_mute,
    output var  logic                          amp_boost_isolate,
    output logic [5:0]                         amp_gain_code,
    output var  logic                          boost_20db_en
);

    import ipc_pkg::*;

    // Index of a word address
    function automatic logic [5:0] word_index(input logic [IPC_ADDR_W-1:0] a);
        return a[IPC_ADDR_W-1:2];
    endfunction

    // Whether an index answers OKAY; reserved words are mapped and read zero
    function automatic logic map_hit(input logic [5:0] idx);
        return (idx >= IPC_IDX_RSVD_A && idx <= IPC_IDX_BOOST) || idx == IPC_IDX_STATUS;
    endfunction

    ipc_gain_if gif ();

    logic                  aw_got;
    logic                  next_aw_got;
    logic [IPC_ADDR_W-1:0] aw_addr;
    logic [IPC_ADDR_W-1:0] next_aw_addr;
    logic                  w_got;
    logic                  next_w_got;
    logic [31:0]           w_data;
    logic [31:0]           next_w_data;
    logic [3:0]            w_strb;
    logic [3:0]            next_w_strb;
    logic                  next_awready;
    logic                  next_wready;
    logic                  next_bvalid;
    logic [1:0]            next_bresp;
    logic                  do_write;
    logic [5:0]            wr_idx;

    logic                  next_arready;
    logic                  next_rvalid;
    logic [31:0]           next_rdata;
    logic [1:0]            next_rresp;
    logic [5:0]            rd_idx;

    logic                  gain_zc;
    logic                  next_gain_zc;
    logic [5:0]            gain_target;
    logic [5:0]            next_gain_target;
    logic                  next_lvl_zc;
    logic                  next_bias_sel;
    logic                  next_aux_mode;
    logic                  next_aux_neg;
    logic                  next_mic_neg;
    logic                  next_mic_pos;
    logic                  next_mute;
    logic                  next_boost;
    logic                  gain_wr;
    logic                  gain_written;

    // Write fires once both address and data are held and no response is waiting
    assign do_write = aw_got && w_got && !s_axi_bvalid;
    assign wr_idx   = word_index(aw_addr);
    assign rd_idx   = word_index(s_axi_araddr);

    // Write channels: address and data are caught in either order
    always_comb begin
        next_aw_got  = aw_got;
        next_aw_addr = aw_addr;
        next_w_got   = w_got;
        next_w_data  = w_data;
        next_w_strb  = w_strb;
        next_bvalid  = s_axi_bvalid;
        next_bresp   = s_axi_bresp;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_got  = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_got  = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (do_write) begin
            next_aw_got = 1'b0;
            next_w_got  = 1'b0;
            next_bvalid = 1'b1;
            next_bresp  = map_hit(wr_idx) ? IPC_RESP_OKAY : IPC_RESP_DECERR;
        end
        // Ready drops while a word is held, so one write at most is in flight
        next_awready = !next_aw_got && !next_bvalid;
        next_wready  = !next_w_got && !next_bvalid;
    end

    // Write channel registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            aw_got        <= 1'b0;
            aw_addr       <= '0;
            w_got         <= 1'b0;
            w_data        <= '0;
            w_strb        <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= IPC_RESP_OKAY;
        end else if (ce) begin
            aw_got        <= next_aw_got;
            aw_addr       <= next_aw_addr;
            w_got         <= next_w_got;
            w_data        <= next_w_data;
            w_strb        <= next_w_strb;
            s_axi_awready <= next_awready;
            s_axi_wready  <= next_wready;
            s_axi_bvalid  <= next_bvalid;
            s_axi_bresp   <= next_bresp;
        end
    end

    // Field updates; low byte lane carries bits 7:0, next lane carries bit 8
    always_comb begin
        next_lvl_zc      = level_ctl_zero_cross_en;
        next_bias_sel    = mic_bias_level_sel;
        next_aux_mode    = aux_input_mode;
        next_aux_neg     = aux_to_amp_neg_en;
        next_mic_neg     = mic_neg_to_amp_neg_en;
        next_mic_pos     = mic_pos_to_amp_pos_sel;
        next_gain_zc     = gain_zc;
        next_mute        = amp_mute;
        next_gain_target = gain_target;
        next_boost       = boost_20db_en;
        gain_wr          = 1'b0;
        if (do_write) begin
            case (wr_idx)
                IPC_IDX_LVL_ZC: begin
                    if (w_strb[0]) next_lvl_zc = w_data[IPC_BIT_LVL_ZC];
                end
                IPC_IDX_ROUTING: begin
                    if (w_strb[1]) next_bias_sel = w_data[IPC_BIT_BIAS_SEL];
                    if (w_strb[0]) begin
                        next_aux_mode = w_data[IPC_BIT_AUX_MODE];
                        next_aux_neg  = w_data[IPC_BIT_AUX_NEG];
                        next_mic_neg  = w_data[IPC_BIT_MIC_NEG];
                        next_mic_pos  = w_data[IPC_BIT_MIC_POS];
                    end
                end
                IPC_IDX_AMP_GAIN: begin
                    if (w_strb[0]) begin
                        next_gain_zc     = w_data[IPC_BIT_GAIN_ZC];
                        next_mute        = w_data[IPC_BIT_MUTE];
                        next_gain_target = w_data[IPC_GAIN_MSB:0];
                        gain_wr          = 1'b1;
                    end
                end
                IPC_IDX_BOOST: begin
                    if (w_strb[1]) next_boost = w_data[IPC_BIT_BOOST];
                end
                default: begin
                    // Reserved and unmapped words ignore writes
                end
            endcase
        end
    end

    // Field registers, which drive the analogue selects directly
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            level_ctl_zero_cross_en <= IPC_RST_LVL_ZC;
            mic_bias_level_sel      <= IPC_RST_BIAS_SEL;
            aux_input_mode          <= IPC_RST_AUX_MODE;
            aux_to_amp_neg_en       <= IPC_RST_AUX_NEG;
            mic_neg_to_amp_neg_en   <= IPC_RST_MIC_NEG;
            mic_pos_to_amp_pos_sel  <= IPC_RST_MIC_POS;
            gain_zc                 <= IPC_RST_GAIN_ZC;
            amp_mute                <= IPC_RST_MUTE;
            amp_boost_isolate       <= IPC_RST_MUTE;
            gain_target             <= IPC_RST_GAIN;
            gain_written            <= 1'b0;
            boost_20db_en           <= IPC_RST_BOOST;
        end else if (ce) begin
            level_ctl_zero_cross_en <= next_lvl_zc;
            mic_bias_level_sel      <= next_bias_sel;
            aux_input_mode          <= next_aux_mode;
            aux_to_amp_neg_en       <= next_aux_neg;
            mic_neg_to_amp_neg_en   <= next_mic_neg;
            mic_pos_to_amp_pos_sel  <= next_mic_pos;
            gain_zc                 <= next_gain_zc;
            amp_mute                <= next_mute;
            amp_boost_isolate       <= next_mute;
            gain_target             <= next_gain_target;
            gain_written            <= gain_wr;
            boost_20db_en           <= next_boost;
        end
    end

    // Gain code passes through the zero-cross update unit before the amplifier
    assign gif.target   = gain_target;
    assign gif.zc_en    = gain_zc;
    // Pulse lags the write by one cycle so the unit sees the new mode and code together
    assign gif.wr_pulse = gain_written && ce;
    assign amp_gain_code = gif.applied;

    ipc_gain_apply u_gain (
        .sys_clk    (sys_clk),
        .rst        (rst),
        .ce         (ce),
        .zero_cross (zero_cross),
        .gif        (gif.unit)
    );

    // Read channel: one read in flight, data latched at address handshake
    always_comb begin
        next_rvalid = s_axi_rvalid;
        next_rdata  = s_axi_rdata;
        next_rresp  = s_axi_rresp;
        if (s_axi_rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rdata  = 32'h0000_0000;
            next_rresp  = map_hit(rd_idx) ? IPC_RESP_OKAY : IPC_RESP_DECERR;
            case (rd_idx)
                IPC_IDX_LVL_ZC: begin
                    next_rdata[IPC_BIT_LVL_ZC] = level_ctl_zero_cross_en;
                end
                IPC_IDX_ROUTING: begin
                    next_rdata[IPC_BIT_BIAS_SEL] = mic_bias_level_sel;
                    next_rdata[IPC_BIT_AUX_MODE] = aux_input_mode;
                    next_rdata[IPC_BIT_AUX_NEG]  = aux_to_amp_neg_en;
                    next_rdata[IPC_BIT_MIC_NEG]  = mic_neg_to_amp_neg_en;
                    next_rdata[IPC_BIT_MIC_POS]  = mic_pos_to_amp_pos_sel;
                end
                IPC_IDX_AMP_GAIN: begin
                    next_rdata[IPC_BIT_GAIN_ZC]    = gain_zc;
                    next_rdata[IPC_BIT_MUTE]       = amp_mute;
                    next_rdata[IPC_GAIN_MSB:0]     = gain_target;
                end
                IPC_IDX_BOOST: begin
                    next_rdata[IPC_BIT_BOOST] = boost_20db_en;
                end
                IPC_IDX_STATUS: begin
                    // Shows the code the amplifier really uses, which may lag the stored one
                    next_rdata[IPC_GAIN_MSB:0]   = gif.applied;
                    next_rdata[IPC_BIT_PENDING]  = gif.pending;
                end
                default: begin
                    // Reserved and unmapped words read zero
                end
            endcase
        end
        next_arready = !next_rvalid;
    end

    // Read channel registers
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= IPC_RESP_OKAY;
        end else if (ce) begin
            s_axi_arready <= next_arready;
            s_axi_rvalid  <= next_rvalid;
            s_axi_rdata   <= next_rdata;
            s_axi_rresp   <= next_rresp;
        end
    end

    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    lvl_zc_write_a: assert property (ce && do_write && wr_idx == IPC_IDX_LVL_ZC && w_strb[0]
            |=> level_ctl_zero_cross_en == $past(w_data[IPC_BIT_LVL_ZC]))
        else $error("level zero-cross bit not written");
    bias_write_a: assert property (ce && do_write && wr_idx == IPC_IDX_ROUTING && w_strb[1]
            |=> mic_bias_level_sel == $past(w_data[IPC_BIT_BIAS_SEL]))
        else $error("mic bias select not written");
    aux_mode_write_a: assert property (ce && do_write && wr_idx == IPC_IDX_ROUTING && w_strb[0]
            |=> aux_input_mode == $past(w_data[IPC_BIT_AUX_MODE]))
        else $error("aux mode not written");
    routing_write_a: assert property (ce && do_write && wr_idx == IPC_IDX_ROUTING && w_strb[0]
            |=> {aux_to_amp_neg_en, mic_neg_to_amp_neg_en, mic_pos_to_amp_pos_sel}
                == $past(w_data[2:0]))
        else $error("routing switches not written");
    mute_isolate_a: assert property (amp_boost_isolate == amp_mute)
        else $error("boost isolation differs from mute");
    mute_write_a: assert property (ce && do_write && wr_idx == IPC_IDX_AMP_GAIN && w_strb[0]
            |=> amp_mute == $past(w_data[IPC_BIT_MUTE]))
        else $error("mute bit not written");
    gain_zc_hold_a: assert property (ce && do_write && wr_idx == IPC_IDX_AMP_GAIN && w_strb[0]
            && w_data[IPC_BIT_GAIN_ZC] && !zero_cross |=> $stable(amp_gain_code))
        else $error("gain moved on write with zero cross on");
    gain_target_a: assert property (ce && do_write && wr_idx == IPC_IDX_AMP_GAIN && w_strb[0]
            |=> gain_target == $past(w_data[IPC_GAIN_MSB:0]))
        else $error("gain code not stored");
    boost_write_a: assert property (ce && do_write && wr_idx == IPC_IDX_BOOST && w_strb[1]
            |=> boost_20db_en == $past(w_data[IPC_BIT_BOOST]))
        else $error("boost select not written");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready
            |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");

    gain_write_c: cover property (do_write && wr_idx == IPC_IDX_AMP_GAIN);
    status_read_c: cover property (s_axi_arvalid && s_axi_arready && rd_idx == IPC_IDX_STATUS);
    decerr_c: cover property (s_axi_rvalid && s_axi_rresp == IPC_RESP_DECERR);

endmodule // ipc_input_path_regs
`default_nettype wire

// ==== tb_top.sv ====
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import ipc_pkg::*;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        zero_cross = 1'b0;
    logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, rv, lfsr = 32'd32052;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic        awready, wready, bvalid, arready, rvalid, pend;
    logic [1:0]  bresp, rresp, resp;
    logic        level_ctl_zero_cross_en, mic_bias_level_sel, aux_input_mode, aux_to_amp_neg_en;
    logic        mic_neg_to_amp_neg_en, mic_pos_to_amp_pos_sel, amp_mute, amp_boost_isolate;
    logic        boost_20db_en;
    logic [5:0]  amp_gain_code, applied;
    logic [15:0] mdl [41:47];
    int          errors = 0, samples_checked = 0, idx;

    ipc_input_path_regs dut (
        .sys_clk(sys_clk), .rst(rst), .ce(1'b1), .zero_cross(zero_cross),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .level_ctl_zero_cross_en(level_ctl_zero_cross_en), .mic_bias_level_sel(mic_bias_level_sel),
        .aux_input_mode(aux_input_mode), .aux_to_amp_neg_en(aux_to_amp_neg_en),
        .mic_neg_to_amp_neg_en(mic_neg_to_amp_neg_en), .amp_mute(amp_mute),
        .mic_pos_to_amp_pos_sel(mic_pos_to_amp_pos_sel), .amp_boost_isolate(amp_boost_isolate),
        .amp_gain_code(amp_gain_code), .boost_20db_en(boost_20db_en));

    // 40 MHz clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    function automatic logic [31:0] lfsr_next(input logic [31:0] v);
        return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
    endfunction

    // Write: each channel released at its own handshake, bready held until bvalid
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        @(posedge sys_clk);
        n = 0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid && n < 200);
        resp = bresp;
        bready <= 1'b0;
        if (n >= 200) errors++;
    endtask

    task automatic rd(input logic [7:0] a);
        int n;
        @(posedge sys_clk);
        n = 0;
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
            if (arready) arvalid <= 1'b0;
        end while (!rvalid && n < 200);
        rv = rdata;
        resp = rresp;
        rready <= 1'b0;
        if (n >= 200) errors++;
    endtask

    task automatic mdl_reset;
        foreach (mdl[i]) mdl[i] = 16'h0;
        mdl[44] = 16'h0002;
        mdl[45] = 16'h0050;
        applied = 6'h10;
        pend = 1'b0;
    endtask

    // Model write; reserved places keep zero whatever is written
    task automatic wm(input int i, input logic [31:0] d, input logic [3:0] s);
        logic [15:0] m;
        wr(8'(i * 4), d, s);
        `CHK(resp, IPC_RESP_OKAY)
        m = {7'h0, s[1], {8{s[0]}}};
        case (i)
            42: m &= 16'h0002;
            44: m &= 16'h010F;
            45: m &= 16'h00FF;
            47: m &= 16'h0100;
            default: m = 16'h0;
        endcase
        mdl[i] = (mdl[i] & ~m) | (d[15:0] & m);
        if (i == 45 && s[0] && !d[7]) applied = d[5:0];
        if (i == 45 && s[0]) pend = d[7];
    endtask

    // Read back the whole bank and the status word, then the field outputs
    task automatic chk_regs;
        for (int i = 41; i <= 47; i++) begin
            rd(8'(i * 4));
            `CHK({resp, rv}, {IPC_RESP_OKAY, 16'h0, mdl[i]})
        end
        rd(8'hFC);
        `CHK(rv & 32'h13F, {23'h0, pend, 2'h0, applied})
        `CHK(level_ctl_zero_cross_en, mdl[42][1])
        `CHK(mic_bias_level_sel, mdl[44][8])
        `CHK(aux_input_mode, mdl[44][3])
        `CHK(aux_to_amp_neg_en, mdl[44][2])
        `CHK(mic_neg_to_amp_neg_en, mdl[44][1])
        `CHK(mic_pos_to_amp_pos_sel, mdl[44][0])
        `CHK({amp_mute, amp_boost_isolate}, {2{mdl[45][6]}})
        `CHK(amp_gain_code, applied)
        `CHK(boost_20db_en, mdl[47][8])
    endtask

    task automatic report_and_stop;
        $display("errors=%0d samples_checked=%0d", errors, samples_checked);
        if (errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    initial begin
        mdl_reset();
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        chk_regs();
        // Random words and strobes; zero-cross mode kept off so gain applies at once
        repeat (24) begin
            repeat (8) lfsr = lfsr_next(lfsr);
            idx = 41 + int'(lfsr[7:0]) % 7;
            wm(idx, lfsr & ~32'h80, lfsr[11:8]);
            chk_regs();
        end
        // Deferred gain at both ends of the code range
        for (int k = 0; k < 2; k++) begin
            wm(45, {24'h0, 2'b10, (k == 0) ? 6'h3F : 6'h00}, 4'h1);
            repeat (4) @(posedge sys_clk);
            chk_regs();
            zero_cross <= 1'b1;
            @(posedge sys_clk);
            zero_cross <= 1'b0;
            applied = mdl[45][5:0];
            pend = 1'b0;
            chk_regs();
        end
        wr(8'hA4, 32'hFFFF, 4'hF);
        `CHK(resp, IPC_RESP_OKAY)
        wr(8'h00, 32'hFFFF, 4'hF);
        `CHK(resp, IPC_RESP_DECERR)
        rd(8'h00);
        `CHK({resp, rv}, {IPC_RESP_DECERR, 32'h0})
        chk_regs();
        // Second reset in mid-run brings every field back
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        mdl_reset();
        chk_regs();
        report_and_stop();
    end

    // Whole run needs under a thousand cycles; this cuts a hang short
    initial begin
        #(20000 * 25);
        errors++;
        report_and_stop();
    end
endmodule // tb_top
`default_nettype wire
